/* rtl/rbs_defines.svh */
`ifndef RBS_DEFINES_SVH
`define RBS_DEFINES_SVH

// opcode values and compare masks (10-bit instruction word)
`define RBS_OP_RET_IRQ 10'h046
`define RBS_OP_RTS 10'h045
`define RBS_OP_BANK_SET 10'h041
`define RBS_OP_BIT_SET 10'h05C
`define RBS_MASK_BIT_SET 10'h3FC
`define RBS_OP_TBL_REF 10'h080
`define RBS_MASK_TBL_REF 10'h3C0
// field positions
`define RBS_BIT_J_LSB 0
`define RBS_TBL_P_LSB 0
`define RBS_PAGE_BIT_SIX 6
`define RBS_PAGE_BIT_FIVE 5
// cycle counts
`define RBS_RTS_CYCLES 2
`define RBS_RET_IRQ_CYCLES 1
// reset values and interrupt vector
`define RBS_PC_RST 14'h0000
`define RBS_IRQ_VEC 14'h0100
`define RBS_CTX_RST 16'h0000

`endif

/* rtl/rbs_pkg.sv */
package rbs_pkg;

   // context saved on interrupt entry and restored on return
   typedef struct packed {
      logic [3:0] reg_b;
      logic       nop_mode;
      logic       carry_flag;
      logic [1:0] ptr_z;
      logic [3:0] ptr_x;
      logic [3:0] ptr_y;
   } rbs_ctx_t;

   typedef enum logic [0:0] {
      RBS_RUN,
      RBS_RTS2
   } rbs_state_t;

endpackage

/* rtl/rbs_decoder.sv */
`timescale 1ns/1ns
// Functional notes
// - return_from_interrupt_op pops pc from return_stack, one word one cycle
// - interrupt return restores pointer, carry, skip, nop mode, register B
// - return with skip: two cycles, pop pc, then skip next instruction
// - memory_bit_set_op sets bit j of nibble at data_pointer, one cycle
// - after bank flag set, table_reference_op forces page_bit_six high
// - smaller-rom member with bank flag reaches only pages 64 through 95
`include "rbs_defines.svh"

module rbs_decoder
   import rbs_pkg::*;
#(
   parameter int PC_W = 14,
   parameter int STACK_DEPTH = 8,
   parameter int SP_W = 3,
   parameter bit SMALL_ROM = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [9:0] instr_word,
   input wire logic irq_take,
   input wire logic call_take,
   input wire logic [PC_W-1:0] call_target,
   input wire logic ctx_wr,
   input wire rbs_ctx_t ctx_wdata,
   output logic [PC_W-1:0] pc_o,
   output logic [SP_W-1:0] stack_index_o,
   output rbs_ctx_t ctx_o,
   output logic skip_o,
   output logic busy_o,
   output logic bank_o,
   output logic tbl_req_o,
   output logic [6:0] tbl_page_o,
   output logic [3:0] mem_nibble_o
);

   localparam int MEM_AW = 10;

   logic [PC_W-1:0] pc_q;
   logic [SP_W-1:0] stack_index_q;
   logic [PC_W-1:0] return_stack [STACK_DEPTH];
   logic [3:0] mem [2**MEM_AW];
   rbs_ctx_t ctx_q;
   rbs_ctx_t saved_ctx_q;
   logic saved_skip_q;
   logic skip_q;
   logic bank_q;
   logic tbl_req_q;
   logic [6:0] tbl_page_q;
   logic [3:0] mem_nibble_q;
   rbs_state_t state_q;

   ///////////////////////////////////////////////////////////////////////////
   // decode

   wire run = (state_q == RBS_RUN);
   wire take_irq = run && irq_take;
   wire take_call = run && !irq_take && call_take;
   wire issue = run && !irq_take && !call_take && instr_valid;
   wire squash = issue && skip_q;
   wire exec = issue && !skip_q;
   wire is_ret_irq = exec && (instr_word == `RBS_OP_RET_IRQ);
   wire is_rts = exec && (instr_word == `RBS_OP_RTS);
   wire is_bank_set = exec && (instr_word == `RBS_OP_BANK_SET);
   wire is_bit_set = exec
      && ((instr_word & `RBS_MASK_BIT_SET) == `RBS_OP_BIT_SET);
   wire is_tbl_ref = exec
      && ((instr_word & `RBS_MASK_TBL_REF) == `RBS_OP_TBL_REF);
   wire [1:0] bit_j = instr_word[`RBS_BIT_J_LSB +: 2];
   wire [5:0] page_p = instr_word[`RBS_TBL_P_LSB +: 6];
   wire [MEM_AW-1:0] ptr_addr = {ctx_q.ptr_z, ctx_q.ptr_x, ctx_q.ptr_y};
   wire [3:0] bit_mask = 4'h1 << bit_j;
   wire [PC_W-1:0] top_entry = return_stack[stack_index_q];
   wire [SP_W-1:0] idx_push = stack_index_q + 1'b1;
   wire [SP_W-1:0] idx_pop = stack_index_q - 1'b1;
   wire [PC_W-1:0] pc_inc = pc_q + 1'b1;
   // bank flag reaches the upper page range; small rom keeps bit five low while the bank flag is set
   wire bit_five = (bank_q && SMALL_ROM) ? 1'b0 : page_p[5];
   wire [6:0] page_sel = {bank_q, bit_five, page_p[4:0]};

   ///////////////////////////////////////////////////////////////////////////
   // sequencer

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pc_q <= `RBS_PC_RST;
         stack_index_q <= '1;
         state_q <= RBS_RUN;
         skip_q <= 1'b0;
      end else begin
         if (take_irq) begin
            stack_index_q <= idx_push;
            pc_q <= `RBS_IRQ_VEC;
            skip_q <= 1'b0;
         end else if (take_call) begin
            stack_index_q <= idx_push;
            pc_q <= call_target;
         end else if (is_ret_irq) begin
            pc_q <= top_entry;
            stack_index_q <= idx_pop;
            skip_q <= saved_skip_q;
         end else if (is_rts) begin
            pc_q <= top_entry;
            stack_index_q <= idx_pop;
            state_q <= RBS_RTS2;
         end else if (state_q == RBS_RTS2) begin
            state_q <= RBS_RUN;
            skip_q <= 1'b1;
         end else if (squash) begin
            pc_q <= pc_inc;
            skip_q <= 1'b0;
         end else if (exec) begin
            pc_q <= pc_inc;
         end
      end
   end

   // stack and memory arrays carry no reset
   always_ff @(posedge core_clk) begin
      if (take_irq) begin
         return_stack[idx_push] <= pc_q;
      end
      if (take_call) begin
         return_stack[idx_push] <= pc_inc;
      end
      if (is_bit_set) begin
         mem[ptr_addr] <= mem[ptr_addr] | bit_mask;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // context, bank flag, table reference

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctx_q <= `RBS_CTX_RST;
         saved_ctx_q <= `RBS_CTX_RST;
         saved_skip_q <= 1'b0;
         bank_q <= 1'b0;
         tbl_req_q <= 1'b0;
         tbl_page_q <= '0;
         mem_nibble_q <= '0;
      end else begin
         tbl_req_q <= is_tbl_ref;
         mem_nibble_q <= mem[ptr_addr];
         if (take_irq) begin
            saved_ctx_q <= ctx_q;
            saved_skip_q <= skip_q;
         end
         if (is_ret_irq) begin
            ctx_q <= saved_ctx_q;
         end else if (ctx_wr && !squash) begin
            ctx_q <= ctx_wdata;
         end
         if (is_bank_set) begin
            bank_q <= 1'b1;
         end
         if (is_tbl_ref) begin
            tbl_page_q <= page_sel;
         end
      end
   end

   assign pc_o = pc_q;
   assign stack_index_o = stack_index_q;
   assign ctx_o = ctx_q;
   assign skip_o = skip_q;
   assign busy_o = (state_q == RBS_RTS2);
   assign bank_o = bank_q;
   assign tbl_req_o = tbl_req_q;
   assign tbl_page_o = tbl_page_q;
   assign mem_nibble_o = mem_nibble_q;

   ///////////////////////////////////////////////////////////////////////////
   // checks

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_rts_issue;
      is_rts;
   endsequence
   sequence s_rts_tail;
      busy_o ##1 (!busy_o && skip_o);
   endsequence

   AST_RET_IRQ_POP: assert property (
      is_ret_irq |=> pc_o == $past(top_entry)
         && stack_index_o == $past(stack_index_q) - 1'b1 && !busy_o)
      else $error("interrupt return pop wrong");
   AST_RET_IRQ_CTX: assert property (
      is_ret_irq |=> ctx_o == $past(saved_ctx_q)
         && skip_o == $past(saved_skip_q))
      else $error("interrupt return context not restored");
   AST_RTS_SEQ: assert property (
      s_rts_issue |=> s_rts_tail)
      else $error("rts sequence wrong");
   AST_RTS_PC: assert property (
      is_rts |=> pc_o == $past(top_entry))
      else $error("rts pc wrong");
   // nibble register trails the memory write by one more edge
   AST_BIT_SET: assert property (
      is_bit_set ##1 (ptr_addr == $past(ptr_addr)) |=>
         mem_nibble_o[$past(bit_j,2)] == 1'b1)
      else $error("bit not set");
   AST_BANK_SET: assert property (
      is_bank_set |=> bank_o)
      else $error("bank flag not set");
   AST_TBL_BANK: assert property (
      is_tbl_ref && bank_q |=> tbl_req_o && tbl_page_o[6])
      else $error("page bit six not forced");
   AST_TBL_RANGE: assert property (
      is_tbl_ref && bank_q |=> tbl_page_o >= 7'h40
         && (SMALL_ROM || tbl_page_o[5:0] == $past(page_p)))
      else $error("bank page outside 64 to 127");
   AST_SMALL_ROM: assert property (
      is_tbl_ref && bank_q && SMALL_ROM |=> tbl_page_o <= 7'h5F
         && tbl_page_o[4:0] == $past(page_p[4:0]))
      else $error("small rom page above 95");
   AST_SKIP_NOP: assert property (
      squash |=> ctx_o == $past(ctx_o) && !skip_o
         && pc_o == $past(pc_o) + 1'b1 && $stable(bank_o))
      else $error("skipped instruction had effect");

endmodule

/* dv/return_bit_set_bank_ops_tb.sv */
`timescale 1ns/1ns
module return_bit_set_bank_ops_tb;
   import rbs_pkg::*;
   logic core_clk, rst, instr_valid, irq_take, call_take, ctx_wr;
   logic [9:0] instr_word;
   logic [13:0] call_target, pc_o, ep, sv;
   rbs_ctx_t ctx_wdata, ctx_o, ca;
   logic [2:0] stack_index_o;
   logic skip_o, busy_o, bank_o, tbl_req_o;
   logic [6:0] tbl_page_o, tbl_page_sm;
   logic [3:0] mem_nibble_o;
   int errors, n_compared;

   rbs_decoder i_dut (.core_clk(core_clk), .rst(rst),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .irq_take(irq_take), .call_take(call_take),
      .call_target(call_target), .ctx_wr(ctx_wr), .ctx_wdata(ctx_wdata),
      .pc_o(pc_o), .stack_index_o(stack_index_o), .ctx_o(ctx_o),
      .skip_o(skip_o), .busy_o(busy_o), .bank_o(bank_o),
      .tbl_req_o(tbl_req_o), .tbl_page_o(tbl_page_o),
      .mem_nibble_o(mem_nibble_o));

   // smaller-rom member, same stimulus, only its table page is judged
   rbs_decoder #(.SMALL_ROM(1'b1)) i_dut_small (.core_clk(core_clk),
      .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
      .irq_take(irq_take), .call_take(call_take),
      .call_target(call_target), .ctx_wr(ctx_wr), .ctx_wdata(ctx_wdata),
      .pc_o(), .stack_index_o(), .ctx_o(), .skip_o(), .busy_o(),
      .bank_o(), .tbl_req_o(), .tbl_page_o(tbl_page_sm),
      .mem_nibble_o());

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   //////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      if (errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic step;
      @(posedge core_clk);
      #1;
   endtask

   task automatic issue(input logic [9:0] w);
      step;
      instr_valid = 1'b1;
      instr_word = w;
      step;
      instr_valid = 1'b0;
   endtask

   task automatic wctx(input rbs_ctx_t c);
      step;
      ctx_wr = 1'b1;
      ctx_wdata = c;
      step;
      ctx_wr = 1'b0;
   endtask

   task automatic do_call(input logic [13:0] t);
      step;
      call_take = 1'b1;
      call_target = t;
      step;
      call_take = 1'b0;
   endtask

   //////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("pc", 16'h0000, 16'(pc_o));
      chk("sidx", 16'h0007, 16'(stack_index_o));
      chk("ctx", 16'h0000, 16'(ctx_o));
      chk("flags", 16'h0000, 16'({skip_o, busy_o, bank_o, tbl_req_o}));
   endtask

   task automatic t_bit_set;
      wctx(rbs_ctx_t'(16'h0135));
      for (int j = 0; j < 4; j++) begin
         issue(10'h05C + 10'(j));
         ep++;
         chk("pc", 16'(ep), 16'(pc_o));
         step;
         chk("nib", 16'h0001, 16'(mem_nibble_o[j]));
      end
   endtask

   task automatic t_return_skip;
      do_call(14'h0200);
      sv = ep + 14'h0001;
      chk("sidx", 16'h0000, 16'(stack_index_o));
      issue(10'h045);
      chk("pc", 16'(sv), 16'(pc_o));
      chk("sidx", 16'h0007, 16'(stack_index_o));
      chk("busy", 16'h0001, 16'(busy_o));
      step;
      chk("busy", 16'h0000, 16'(busy_o));
      chk("skip", 16'h0001, 16'(skip_o));
      issue(10'h041);
      ep = sv + 14'h0001;
      chk("pc", 16'(ep), 16'(pc_o));
      chk("bank", 16'h0000, 16'(bank_o));
      chk("skip", 16'h0000, 16'(skip_o));
   endtask

   // interrupt taken while a skip is pending, so the restore is visible
   task automatic t_interrupt;
      ca = rbs_ctx_t'(16'h5A6C);
      wctx(ca);
      sv = ep + 14'h0001;
      do_call(14'h0300);
      issue(10'h045);
      step;
      chk("skip", 16'h0001, 16'(skip_o));
      step;
      irq_take = 1'b1;
      step;
      irq_take = 1'b0;
      chk("pc", 16'h0100, 16'(pc_o));
      chk("skip", 16'h0000, 16'(skip_o));
      wctx(rbs_ctx_t'(16'h2393));
      issue(10'h046);
      chk("pc", 16'(sv), 16'(pc_o));
      chk("sidx", 16'h0007, 16'(stack_index_o));
      chk("ctx", 16'(ca), 16'(ctx_o));
      chk("skip", 16'h0001, 16'(skip_o));
      issue(10'h041);
      ep = sv + 14'h0001;
      chk("pc", 16'(ep), 16'(pc_o));
      chk("bank", 16'h0000, 16'(bank_o));
   endtask

   task automatic t_bank;
      issue(10'h0AA);
      chk("req", 16'h0001, 16'(tbl_req_o));
      chk("page", 16'h002A, 16'(tbl_page_o));
      chk("small page", 16'h002A, 16'(tbl_page_sm));
      step;
      chk("req", 16'h0000, 16'(tbl_req_o));
      issue(10'h041);
      chk("bank", 16'h0001, 16'(bank_o));
      issue(10'h0BF);
      chk("page", 16'h007F, 16'(tbl_page_o));
      chk("small page", 16'h005F, 16'(tbl_page_sm));
      issue(10'h080);
      chk("page", 16'h0040, 16'(tbl_page_o));
      chk("small page", 16'h0040, 16'(tbl_page_sm));
   endtask

   //////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {instr_valid, irq_take, call_take, ctx_wr} = 4'h0;
      instr_word = 10'h000;
      call_target = 14'h0000;
      ctx_wdata = rbs_ctx_t'(16'h0000);
      ep = 14'h0000;
      repeat (2) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_reset;
      t_bit_set;
      t_return_skip;
      t_interrupt;
      t_bank;
      complete_run;
   end

   initial begin
      #100000;
      errors++;
      complete_run;
   end
endmodule
